// ---- rtl/start_interlock.sv ----
// Start interlock sequencer and edit lock control with AHB-Lite registers.
// Assumes synchronous inputs, one clock, zero-wait AHB-Lite slave port.
//
// What this block does
// [RQ1] Guard off: run at power-up if commanded
// [RQ2] Guard on, run at power-up: trip code 13
// [RQ3] Run off or reset clears interlock trip
// [RQ4] Fresh run command after clearing starts output
// [RQ5] Function code 13 selects the start guard
// [RQ6] Reset with run still high restarts output
// [RQ7] Undervoltage trip reset re-applies the guard
// [RQ8] Controller waits three seconds before run; term_partner adds no wait and the bench holds run through power-up
// [RQ9] Edit lock input blocks parameter edits
// [RQ10] Lock off: edits accepted and stored
// [RQ11] Scope setting decides frequency exemption
// [RQ12] Scope setting can lock without terminal
// [RQ13] Functions assignable to any of five terminals
// [RQ14] Reset held 12 ms, alarm clears promptly
`timescale 1ns/100ps
module start_interlock
  import start_lock_pkg::*;
(
  input  wire logic                           SYS_CLK,       // System clock
  input  wire logic                           RESET_N,       // Async reset, low
  input  wire logic                           CE,            // Clock enable
  // Terminals and drive events
  input  wire logic [start_lock_pkg::NUM_TERMS-1:0] TERM_IN, // Terminal levels
  input  wire logic                           RUN_CMD,       // Run command level
  input  wire logic                           POWER_GOOD,    // Power-up complete
  input  wire logic                           FAULT_RESET_IN, // Reset terminal
  input  wire logic                           KEY_STOP_RESET, // Keypad reset pulse
  input  wire logic                           UNDERVOLT,     // Undervoltage event
  // Parameter edits from keypad or remote device
  input  wire logic                           EDIT_REQ,      // Edit request pulse
  input  wire logic [start_lock_pkg::PARAM_AW-1:0] EDIT_ADDR, // Parameter index
  input  wire logic [start_lock_pkg::PARAM_DW-1:0] EDIT_DATA, // New value
  output      logic                           EDIT_ACCEPT,   // Edit stored
  output      logic                           EDIT_REJECT,   // Edit refused
  output      logic [start_lock_pkg::PARAM_DW-1:0] FREQ_SET, // Stored frequency
  // Drive status
  output      logic                           DRIVE_ON,      // Output running
  output      logic                           ALARM,         // Trip alarm
  output      logic [7:0]                     ERROR_CODE,    // Active error code
  // AHB-Lite slave
  input  wire logic                           HSEL,
  input  wire logic [start_lock_pkg::ADDR_W-1:0] HADDR,
  input  wire logic [1:0]                     HTRANS,
  input  wire logic                           HWRITE,
  input  wire logic [2:0]                     HSIZE,
  input  wire logic [31:0]                    HWDATA,
  input  wire logic                           HREADY,
  output      logic                           HREADYOUT,
  output      logic                           HRESP,
  output      logic [31:0]                    HRDATA
);

  // Register state
  logic [SELS_W-1:0] select_reg;             // Function selectors
  logic [SELS_W-1:0] select_next;
  logic [1:0]        scope_reg;              // Lock scope setting
  logic [1:0]        scope_next;
  logic [31:0]       rdata_reg;              // Read data for data phase
  logic [31:0]       rdata_next;

  // Bus phase capture
  logic              wr_pend_reg;            // Write data phase pending
  logic [ADDR_W-1:0] wr_addr_reg;            // Captured write address
  logic              addr_phase;             // Valid transfer taken
  logic              wr_select;              // Data phase hits selectors
  logic              wr_scope;               // Data phase hits scope

  // Drive sequencing
  drive_state_t      state_reg;              // Current drive state
  drive_state_t      state_next;
  logic [7:0]        code_reg;               // Latched error code
  logic [7:0]        code_next;
  logic              rs_prev_reg;            // Reset terminal last level
  logic              rs_rise;                // Reset terminal onset

  // Decoded input functions
  logic              guard_on;               // Start guard terminal ON
  logic              lock_on;                // Edit lock terminal ON
  logic              lock_any;               // Any edit lock in force
  logic [31:0]       status_word;            // Status read value

  // Terminal function decode
  input_function_map #(
    .NT (NUM_TERMS),
    .SW (SEL_W)
  ) u_map (
    .terms     (TERM_IN),
    .selectors (select_reg),
    .guard_on  (guard_on),
    .lock_on   (lock_on)
  );

  // Parameter store behind the edit lock
  edit_lock_gate #(
    .AW (PARAM_AW),
    .DW (PARAM_DW)
  ) u_gate (
    .clk         (SYS_CLK),
    .rst_n       (RESET_N),
    .ce          (CE),
    .edit_req    (EDIT_REQ),
    .edit_addr   (EDIT_ADDR),
    .edit_data   (EDIT_DATA),
    .term_lock   (lock_on),
    .scope       (scope_reg),
    .edit_accept (EDIT_ACCEPT),
    .edit_reject (EDIT_REJECT),
    .freq_value  (FREQ_SET),
    .lock_any    (lock_any)
  );

  // ---- Bus decode ----

  // Transfer accepted in address phase; slave frozen while CE is low
  assign addr_phase = HSEL & HREADY & HTRANS[1] & CE;
  assign wr_select  = wr_pend_reg & (wr_addr_reg == OFS_SELECT);
  assign wr_scope   = wr_pend_reg & (wr_addr_reg == OFS_SCOPE);

  // Selector and scope writes take the low bits of the word
  assign select_next = wr_select ? HWDATA[SELS_W-1:0] : select_reg;  // see [RQ13]
  assign scope_next  = wr_scope  ? HWDATA[1:0]        : scope_reg;   // see [RQ11]

  // Status word: run, trip, lock, guard, reset hold, error code
  assign status_word = {16'h0000, code_reg, 3'h0,
                        (state_reg == ST_RESET_HOLD),
                        guard_on, lock_any,
                        (state_reg == ST_TRIP),
                        (state_reg == ST_RUN)};

  // Read mux; unmapped addresses read as zero
  assign rdata_next =
    (HADDR == OFS_SELECT) ? {{(32-SELS_W){1'b0}}, select_reg} :
    (HADDR == OFS_SCOPE)  ? {30'h0, scope_reg} :
    (HADDR == OFS_STATUS) ? status_word :
    (HADDR == OFS_FREQ)   ? {{(32-PARAM_DW){1'b0}}, FREQ_SET} :
                            32'h0000_0000;

  // Zero wait state, always OKAY; stalls while frozen
  assign HREADYOUT = CE;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_reg;

  // Address phase capture
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else if (CE) begin
      wr_pend_reg <= addr_phase & HWRITE;
      wr_addr_reg <= HADDR;
    end
  end

  // Read data latched in address phase
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_reg <= 32'h0000_0000;
    end else if (CE && addr_phase && !HWRITE) begin
      rdata_reg <= rdata_next;
    end
  end

  // Configuration registers
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      select_reg <= SELECT_RESET;
      scope_reg  <= SCOPE_RESET;
    end else if (CE) begin
      select_reg <= select_next;
      scope_reg  <= scope_next;
    end
  end

  // ---- Drive sequencing ----

  // Onset of the fault reset terminal
  assign rs_rise = FAULT_RESET_IN & ~rs_prev_reg;

  // Next state and error code
  always_comb begin
    state_next = state_reg;
    code_next  = code_reg;
    unique case (state_reg)
      // Wait for power-up, then check the run command
      ST_POWERUP: begin
        if (POWER_GOOD) begin
          if (RUN_CMD && guard_on) begin
            state_next = ST_TRIP;                // see [RQ2]
            code_next  = ERR_GUARD;              // see [RQ5]
          end else if (RUN_CMD) begin
            state_next = ST_RUN;                 // see [RQ1]
          end else begin
            state_next = ST_STOP;
          end
        end
      end
      // Stopped; a run command starts the output
      ST_STOP: begin
        if (UNDERVOLT) begin
          state_next = ST_TRIP;
          code_next  = ERR_UNDERVOLT;
        end else if (RUN_CMD) begin
          state_next = ST_RUN;                   // see [RQ4]
        end
      end
      // Running; run off stops, undervoltage trips
      ST_RUN: begin
        if (UNDERVOLT) begin
          state_next = ST_TRIP;
          code_next  = ERR_UNDERVOLT;
        end else if (!RUN_CMD) begin
          state_next = ST_STOP;
        end
      end
      // Tripped; reset onset clears the alarm at once
      ST_TRIP: begin
        if (rs_rise) begin
          state_next = ST_RESET_HOLD;            // see [RQ14]
        end else if (KEY_STOP_RESET) begin
          state_next = ST_STOP;                  // see [RQ3]
          code_next  = ERR_NONE;
        end else if (code_reg == ERR_GUARD && !RUN_CMD) begin
          state_next = ST_STOP;                  // see [RQ3]
          code_next  = ERR_NONE;
        end
      end
      // Reset held; act on its release
      ST_RESET_HOLD: begin
        if (!FAULT_RESET_IN) begin
          code_next = ERR_NONE;
          if (code_reg == ERR_UNDERVOLT && guard_on && RUN_CMD) begin
            state_next = ST_TRIP;                // see [RQ7]
            code_next  = ERR_GUARD;
          end else if (RUN_CMD) begin
            state_next = ST_RUN;                 // see [RQ6]
          end else begin
            state_next = ST_STOP;                // see [RQ3]
          end
        end
      end
    endcase
  end

  // Drive state registers
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg   <= ST_POWERUP;
      code_reg    <= ERR_NONE;
      rs_prev_reg <= 1'b0;
    end else if (CE) begin
      state_reg   <= state_next;
      code_reg    <= code_next;
      rs_prev_reg <= FAULT_RESET_IN;
    end
  end

  // Outputs straight from state flops
  assign DRIVE_ON   = (state_reg == ST_RUN);
  assign ALARM      = (state_reg == ST_TRIP);
  assign ERROR_CODE = code_reg;

endmodule // start_interlock

// ---- rtl/start_lock_pkg.sv ----
// Shared constants for the start interlock and edit lock block.
// Assumes a single 50 MHz clock domain and an AHB-Lite register port.
package start_lock_pkg;

  // Terminal and selector geometry
  localparam int NUM_TERMS = 5;              // Programmable input terminals
  localparam int SEL_W     = 6;              // Width of one function selector
  localparam int SELS_W    = NUM_TERMS * SEL_W;

  // Input function codes
  localparam logic [SEL_W-1:0] FUNC_GUARD     = 6'h0d;  // Start interlock
  localparam logic [SEL_W-1:0] FUNC_EDIT_LOCK = 6'h0f;  // Edit lock
  localparam logic [SEL_W-1:0] FUNC_NONE      = 6'h3f;  // Terminal unused

  // Error codes shown while tripped
  localparam logic [7:0] ERR_NONE      = 8'h00;
  localparam logic [7:0] ERR_UNDERVOLT = 8'h09;
  localparam logic [7:0] ERR_GUARD     = 8'h0d;

  // Register map (byte addresses)
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] OFS_SELECT = 8'h00;  // Input function selectors
  localparam logic [7:0] OFS_SCOPE  = 8'h04;  // Lock scope setting
  localparam logic [7:0] OFS_STATUS = 8'h08;  // Drive status, read only
  localparam logic [7:0] OFS_FREQ   = 8'h0c;  // Stored output frequency

  // Values after reset: terminal 1 guard, terminal 2 edit lock, rest unused
  localparam logic [SELS_W-1:0] SELECT_RESET = 30'h3ffff3cd;

  // Lock scope encodings
  typedef enum logic [1:0] {
    SCOPE_TERM_FREQ_FREE = 2'h0,  // Terminal locks all but frequency
    SCOPE_TERM_ALL       = 2'h1,  // Terminal locks everything
    SCOPE_OPER_ALL       = 2'h2,  // Locked by setting, everything
    SCOPE_OPER_FREQ_FREE = 2'h3   // Locked by setting, frequency free
  } scope_t;
  localparam logic [1:0] SCOPE_RESET = 2'h0;

  // Parameter store
  localparam int             PARAM_AW   = 4;
  localparam int             PARAM_DW   = 16;
  localparam logic [3:0]     FREQ_INDEX = 4'h0;
  localparam logic [15:0]    PARAM_RESET = 16'h0000;

  // Status register bit positions
  localparam int STAT_RUN_BIT   = 0;
  localparam int STAT_TRIP_BIT  = 1;
  localparam int STAT_LOCK_BIT  = 2;
  localparam int STAT_GUARD_BIT = 3;
  localparam int STAT_HOLD_BIT  = 4;
  localparam int STAT_CODE_LSB  = 8;

  // Drive sequencing states
  typedef enum logic [4:0] {
    ST_POWERUP    = 5'h01,
    ST_STOP       = 5'h02,
    ST_RUN        = 5'h04,
    ST_TRIP       = 5'h08,
    ST_RESET_HOLD = 5'h10
  } drive_state_t;

endpackage

// ---- rtl/input_function_map.sv ----
// Maps the five programmable terminals onto their assigned functions.
// Assumes terminal levels already synchronous to the system clock.
`timescale 1ns/100ps
module input_function_map
  import start_lock_pkg::*;
#(
  parameter int NT = 5,                      // Number of terminals
  parameter int SW = 6                       // Selector width
) (
  input  wire logic [NT-1:0]    terms,       // Terminal levels, high is ON
  input  wire logic [NT*SW-1:0] selectors,   // One selector per terminal
  output      logic             guard_on,    // Start interlock input ON
  output      logic             lock_on      // Edit lock input ON
);

  // True when any ON terminal carries the given function code
  function automatic logic func_active(input logic [SW-1:0] code,
                                       input logic [NT-1:0] lv,
                                       input logic [NT*SW-1:0] sel);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NT; i++) begin
      if (lv[i] && (sel[i*SW +: SW] == code)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Any terminal may carry either function (see [RQ13])
  assign guard_on = func_active(SW'(FUNC_GUARD), terms, selectors);     // see [RQ5]
  assign lock_on  = func_active(SW'(FUNC_EDIT_LOCK), terms, selectors); // see [RQ9]

endmodule // input_function_map

// ---- rtl/edit_lock_gate.sv ----
// Parameter store with edit lock gating for keypad and remote edits.
// Assumes one edit request pulse per accepted edit, synchronous inputs.
`timescale 1ns/100ps
module edit_lock_gate
  import start_lock_pkg::*;
#(
  parameter int AW = 4,                      // Parameter index width
  parameter int DW = 16                      // Parameter word width
) (
  input  wire logic          clk,            // System clock
  input  wire logic          rst_n,          // Asynchronous reset, low
  input  wire logic          ce,             // Clock enable
  input  wire logic          edit_req,       // Edit request pulse
  input  wire logic [AW-1:0] edit_addr,      // Parameter index
  input  wire logic [DW-1:0] edit_data,      // New value
  input  wire logic          term_lock,      // Edit lock terminal ON
  input  wire logic [1:0]    scope,          // Lock scope setting
  output      logic          edit_accept,    // Edit stored, pulse
  output      logic          edit_reject,    // Edit refused, pulse
  output      logic [DW-1:0] freq_value,     // Stored output frequency
  output      logic          lock_any        // Some lock in force
);

  logic [DW-1:0] param_mem [2**AW];          // Parameter words
  logic          accept_reg;                 // Accept pulse flop
  logic          reject_reg;                 // Reject pulse flop
  logic          is_freq;                    // Edit targets frequency
  logic          freq_free;                  // Scope exempts frequency
  logic          locked;                     // This edit is blocked

  // Lock decode; the setting alone can lock (see [RQ12])
  assign lock_any  = term_lock | scope[1];
  assign freq_free = (scope == SCOPE_TERM_FREQ_FREE) |
                     (scope == SCOPE_OPER_FREQ_FREE);         // see [RQ11]
  assign is_freq   = (edit_addr == AW'(FREQ_INDEX));
  assign locked    = lock_any & ~(is_freq & freq_free);       // see [RQ9]

  // Verdict pulses, one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accept_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else if (ce) begin
      accept_reg <= edit_req & ~locked;
      reject_reg <= edit_req & locked;
    end
  end

  // Store only unlocked edits (see [RQ10])
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2**AW; i++) begin
        param_mem[i] <= DW'(PARAM_RESET);
      end
    end else if (ce && edit_req && !locked) begin
      param_mem[edit_addr] <= edit_data;
    end
  end

  assign edit_accept = accept_reg;
  assign edit_reject = reject_reg;
  assign freq_value  = param_mem[FREQ_INDEX];

endmodule // edit_lock_gate

// ---- verification/start_interlock_assertions.sv ----
// Checker for the start interlock and edit lock block ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/100ps
module start_interlock_assertions
  import start_lock_pkg::*;
(
  input wire logic                 SYS_CLK,
  input wire logic                 RESET_N,
  input wire logic                 CE,
  input wire logic                 RUN_CMD,
  input wire logic                 FAULT_RESET_IN,
  input wire logic                 KEY_STOP_RESET,
  input wire logic                 UNDERVOLT,
  input wire logic                 EDIT_REQ,
  input wire logic [PARAM_AW-1:0]  EDIT_ADDR,
  input wire logic [PARAM_DW-1:0]  EDIT_DATA,
  input wire logic                 EDIT_ACCEPT,
  input wire logic                 EDIT_REJECT,
  input wire logic [PARAM_DW-1:0]  FREQ_SET,
  input wire logic                 DRIVE_ON,
  input wire logic                 ALARM,
  input wire logic [7:0]           ERROR_CODE,
  input wire logic                 HREADYOUT,
  input wire logic                 HRESP
);
  // Single domain: one clock and one reset for all checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  a_trip_stopped: assert property (ALARM |-> !DRIVE_ON && ERROR_CODE != ERR_NONE)
    else $error("trip with output on or no code");
  a_runoff_clear: assert property (ALARM && CE && ERROR_CODE == ERR_GUARD && !RUN_CMD
    && !FAULT_RESET_IN |=> !ALARM && ERROR_CODE == ERR_NONE)
    else $error("run off did not clear interlock trip");
  a_key_clear: assert property (ALARM && CE && KEY_STOP_RESET && !FAULT_RESET_IN
    ##1 RUN_CMD |=> DRIVE_ON)
    else $error("keypad reset did not clear and restart");
  a_reset_clear: assert property (ALARM && CE && $rose(FAULT_RESET_IN)
    |=> !ALARM && !DRIVE_ON)
    else $error("alarm kept after reset onset");
  a_start_cause: assert property ($rose(DRIVE_ON) |-> $past(RUN_CMD))
    else $error("output started without run command");
  a_uv_trip: assert property (DRIVE_ON && CE && UNDERVOLT
    |=> ALARM && ERROR_CODE == ERR_UNDERVOLT)
    else $error("undervoltage did not trip");
  a_edit_answer: assert property (EDIT_REQ && CE |=> EDIT_ACCEPT != EDIT_REJECT)
    else $error("edit answer missing or double");
  a_edit_cause: assert property (EDIT_ACCEPT || EDIT_REJECT |-> $past(EDIT_REQ))
    else $error("edit answer without request");
  a_freq_store: assert property (EDIT_ACCEPT && $past(EDIT_ADDR) == FREQ_INDEX
    |-> FREQ_SET == $past(EDIT_DATA))
    else $error("accepted frequency not stored");
  a_freq_guarded: assert property ($changed(FREQ_SET) |-> EDIT_ACCEPT)
    else $error("frequency changed without accepted edit");
  a_bus_okay: assert property (HREADYOUT == CE && !HRESP)
    else $error("bus ready or response wrong");

  // Main scenarios reached
  c_guard_trip: cover property (ALARM && ERROR_CODE == ERR_GUARD);
  c_uv_trip: cover property (ALARM && ERROR_CODE == ERR_UNDERVOLT);
  c_reject: cover property (EDIT_REJECT);
  c_start: cover property ($rose(DRIVE_ON));
endmodule // start_interlock_assertions

bind start_interlock start_interlock_assertions u_start_interlock_assertions (.*);

// ---- verification/term_partner.sv ----
// Model of the outside controller driving run and fault reset terminals.
// Assumes the bench asks for run level and reset pulses at clock edges.
`timescale 1ns/100ps
module term_partner #(
  parameter int HOLD = 6                 // Reset hold, scaled down
) (
  input  wire logic clk,                 // System clock
  input  wire logic rst_n,               // Bench reset, low
  input  wire logic run_want,            // Run level asked for
  input  wire logic rst_go,              // Reset pulse asked for
  output      logic run_cmd,             // Run terminal
  output      logic fault_reset,         // Reset terminal
  output      logic busy                 // Reset pulse in progress
);
  logic [7:0] cnt_reg;                   // Hold cycles left

  // Run follows the request; the bench chooses when
  assign run_cmd = run_want;
  assign fault_reset = cnt_reg != 8'h00;
  assign busy = fault_reset;

  // Hold the reset terminal for the full pulse width
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_reg <= 8'h00;
    else if (rst_go && cnt_reg == 8'h00) cnt_reg <= 8'(HOLD);
    else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
  end
endmodule // term_partner

// ---- verification/tb_top.sv ----
// Bench for the start interlock and edit lock block.
// Assumes the terminal partner model and the bound checker.
`timescale 1ns/100ps
module tb_top;
  import start_lock_pkg::*;
  logic SYS_CLK = 0, RESET_N = 0, CE = 1, POWER_GOOD = 0;
  logic KEY_STOP_RESET = 0, UNDERVOLT = 0, EDIT_REQ = 0;
  logic run_want = 0, rst_go = 0, rst_busy;        // Partner requests
  logic RUN_CMD, FAULT_RESET_IN, EDIT_ACCEPT, EDIT_REJECT;
  logic DRIVE_ON, ALARM, HREADYOUT, HRESP, HSEL = 0, HWRITE = 0;
  logic [NUM_TERMS-1:0] TERM_IN = '0;              // Terminal levels
  logic [PARAM_AW-1:0] EDIT_ADDR = '0;
  logic [PARAM_DW-1:0] EDIT_DATA = '0, FREQ_SET, exp_freq = PARAM_RESET;
  logic [7:0] ERROR_CODE, HADDR = '0;
  logic [1:0] HTRANS = '0;
  logic [2:0] HSIZE = 3'h2;                        // Whole words only
  logic [31:0] HWDATA = '0, HRDATA, r, rs = 32'd41018;
  logic [1:0] q_exp[$];                            // Expected edit answers
  int error_cnt = 0, n_compared = 0;
  bit lk;

  // Free running clock
  always #10 SYS_CLK = ~SYS_CLK;

  start_interlock u_start_interlock (.*, .HREADY(HREADYOUT));
  term_partner u_term_partner (.clk(SYS_CLK), .rst_n(RESET_N), .run_want(run_want),
    .rst_go(rst_go), .run_cmd(RUN_CMD), .fault_reset(FAULT_RESET_IN), .busy(rst_busy));

  task cyc(input int n); repeat (n) @(posedge SYS_CLK); endtask
  task settle; cyc(2); #1; endtask

  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function logic [31:0] xs();
    rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5;
    return rs;
  endfunction

  // One AHB-Lite single transfer, entered at a clock edge
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1; HTRANS <= 2'h2; HADDR <= a; HWRITE <= w;
    do cyc(1); while (HREADYOUT !== 1'b1);
    HSEL <= 0; HTRANS <= 2'h0; HWDATA <= d;
    do cyc(1); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask

  // Power cycle with chosen run level and terminals
  task reboot(input logic run, input logic [4:0] t);
    RESET_N <= 0; POWER_GOOD <= 0; run_want <= run; TERM_IN <= t;
    cyc(3); RESET_N <= 1;
    cyc(2); POWER_GOOD <= 1;
    settle;
  endtask

  // Reset terminal pulse through the partner
  task pulse_reset;
    cyc(1); rst_go <= 1; cyc(1); rst_go <= 0;
    cyc(3); #1;
    check(ALARM, 0);
    while (rst_busy) cyc(1);
    settle;
  endtask

  // Edit request with its expected answer noted
  task edit(input logic [3:0] a, input logic acc);
    logic [31:0] d;
    d = xs();
    EDIT_REQ <= 1; EDIT_ADDR <= a; EDIT_DATA <= d[15:0];
    q_exp.push_back({acc, !acc});
    if (acc && a == FREQ_INDEX) exp_freq = d[15:0];
    cyc(1); EDIT_REQ <= 0; cyc(1);
  endtask

  // Edit answers checked against the oldest note
  always @(posedge SYS_CLK) begin
    if (EDIT_ACCEPT | EDIT_REJECT) begin
      if (q_exp.size() == 0) check(1, 0);
      else check({EDIT_ACCEPT, EDIT_REJECT}, q_exp.pop_front());
    end
  end

  task end_of_test;
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #400000;
    error_cnt++;
    end_of_test;
  end

  initial begin
    // Guard on terminal 1, run held through power-up
    reboot(1, 5'h01);
    check(ALARM, 1);
    check(ERROR_CODE, ERR_GUARD);
    cyc(1); ahb(0, OFS_STATUS, 0);
    check(r[15:8], ERR_GUARD);
    check(HRESP, 0);
    run_want <= 0; settle;
    check(ALARM, 0);
    check(ERROR_CODE, ERR_NONE);
    cyc(1); run_want <= 1; settle;
    check(DRIVE_ON, 1);
    // Reset pulse with run still high
    reboot(1, 5'h01);
    pulse_reset;
    check(DRIVE_ON, 1);
    // Undervoltage trip, reset pulse, guard again
    cyc(1); UNDERVOLT <= 1; cyc(1); UNDERVOLT <= 0; cyc(1); #1;
    check(ERROR_CODE, ERR_UNDERVOLT);
    pulse_reset;
    check(ERROR_CODE, ERR_GUARD);
    cyc(1); KEY_STOP_RESET <= 1; cyc(1); KEY_STOP_RESET <= 0; cyc(2); #1;
    check(DRIVE_ON, 1);
    // Guard off: run resumes at power-up
    reboot(1, 5'h00);
    check(DRIVE_ON, 1);
    // Clock enable low freezes the drive and stalls the bus
    CE <= 0; run_want <= 0; cyc(3); #1;
    check(DRIVE_ON, 1);
    check(HREADYOUT, 0);
    CE <= 1; settle;
    check(DRIVE_ON, 0);
    check(HREADYOUT, 1);
    // Register reset values and an unmapped place
    cyc(1); ahb(0, OFS_SELECT, 0);
    check(r, {2'h0, SELECT_RESET});
    ahb(0, OFS_SCOPE, 0);
    check(r, 32'h0);
    ahb(1, 8'h10, 32'hffffffff); ahb(0, 8'h10, 0);
    check(r, 32'h0);
    // Edit lock moved to terminal 4, every scope and lock level
    ahb(1, OFS_SELECT, {2'h0, 6'h3f, FUNC_EDIT_LOCK, 18'h3ffff});
    for (int s = 0; s < 4; s++) begin
      ahb(1, OFS_SCOPE, s);
      for (int k = 0; k < 2; k++) begin
        TERM_IN <= {1'b0, k[0], 1'b0, ~k[0], 1'b0};
        cyc(2);
        for (int a = 0; a < 2; a++) begin
          lk = (k[0] | s[1]) & !(a == 0 && (s == 0 || s == 3));
          edit(4'(a), !lk);
        end
      end
    end
    settle;
    check(FREQ_SET, exp_freq);
    check(q_exp.size(), 0);
    end_of_test;
  end
endmodule // tb_top
